// ===== bcirq_pkg.sv
package bcirq_pkg;

    // Avalon register byte offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_MASK   = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Control register fields
    localparam int CTRL_IE_BIT    = 0;
    // Mask register fields
    localparam int MASK_R55_BIT   = 0;
    localparam int MASK_R65_BIT   = 1;
    localparam int MASK_R75_BIT   = 2;
    localparam int MASK_CLR75_BIT = 4;
    // Status register fields
    localparam int STAT_IE_BIT    = 0;
    localparam int STAT_P55_BIT   = 1;
    localparam int STAT_P65_BIT   = 2;
    localparam int STAT_P75_BIT   = 3;
    localparam int STAT_TRAP_BIT  = 4;
    localparam int STAT_GENERAL_IRQ_BIT  = 5;
    localparam int STAT_ACK_BIT   = 6;
    localparam int STAT_GRANT_BIT = 7;

    // Reset values
    localparam logic       RST_IE   = 1'b0;
    localparam logic [2:0] RST_MASK = 3'h7;
    localparam logic       RST_GRANT = 1'b0;

    // Restart targets
    localparam logic [7:0] VEC_TRAP = 8'h24;
    localparam logic [7:0] VEC_R75  = 8'h3c;
    localparam logic [7:0] VEC_R65  = 8'h34;
    localparam logic [7:0] VEC_R55  = 8'h2c;
    localparam logic [7:0] VEC_NONE = 8'h00;

    // Interrupt source codes
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_TRAP = 3'h1;
    localparam logic [2:0] SRC_R75  = 3'h2;
    localparam logic [2:0] SRC_R65  = 3'h3;
    localparam logic [2:0] SRC_R55  = 3'h4;
    localparam logic [2:0] SRC_GENERAL_IRQ = 3'h5;

    // Synchroniser lanes
    localparam int SYN_READY = 0;
    localparam int SYN_HOLD  = 1;
    localparam int SYN_GENERAL_IRQ  = 2;
    localparam int SYN_R55   = 3;
    localparam int SYN_R65   = 4;
    localparam int SYN_R75   = 5;
    localparam int SYN_TRAP  = 6;
    localparam int SYN_W     = 7;

    typedef enum logic [2:0] {
        ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3, ST_GRANT, ST_HELD, ST_RESUME
    } bcirq_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        io;
    } bcirq_xfer_t;

    typedef struct packed {
        logic [7:0] vector;
        logic       external;
    } bcirq_irq_t;

endpackage : bcirq_pkg

// ===== bcirq_top.sv
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bcirq_top
    import bcirq_pkg::*;
(
    // Clock and reset
    input  wire  logic        clk_sys,
    input  wire  logic        arst_n,
    // Avalon-MM slave
    input  wire  logic [3:0]  avs_address,
    input  wire  logic        avs_read,
    input  wire  logic        avs_write,
    input  wire  logic [31:0] avs_writedata,
    input  wire  logic [3:0]  avs_byteenable,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    // Core side
    input  wire  logic        xfer_req,
    input  wire  bcirq_xfer_t xfer_cmd,
    output logic              xfer_done,
    output logic [7:0]        xfer_rdata,
    input  wire  logic        instr_sample,
    input  wire  logic        halted,
    output logic              irq_take,
    output bcirq_irq_t        irq_info,
    output logic              pc_inhibit,
    output logic              pc_clear,
    // Bus pins
    output logic [15:0]       addr_out,
    output logic              addr_oe,
    input  wire  logic [7:0]  data_in,
    output logic [7:0]        data_out,
    output logic              data_oe,
    output logic              rd_n,
    output logic              rd_oe,
    output logic              wr_n,
    output logic              wr_oe,
    output logic              io_mem,
    output logic              io_mem_oe,
    output logic              irq_ack_strobe_n,
    input  wire  logic        ready,
    input  wire  logic        hold_req,
    output logic              bus_grant_out,
    // Interrupt pins
    input  wire  logic        general_irq,
    input  wire  logic        rst55_in,
    input  wire  logic        rst65_in,
    input  wire  logic        rst75_in,
    input  wire  logic        trap_in
);

    function automatic logic [7:0] vec_of(input logic [2:0] src);
        unique case (src)
            SRC_TRAP: vec_of = VEC_TRAP;
            SRC_R75:  vec_of = VEC_R75;
            SRC_R65:  vec_of = VEC_R65;
            SRC_R55:  vec_of = VEC_R55;
            default:  vec_of = VEC_NONE;
        endcase
    endfunction : vec_of

    // Pin synchronisers
    logic [SYN_W-1:0] syn_a;
    logic [SYN_W-1:0] syn_b;
    logic [SYN_W-1:0] syn_c;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            syn_a <= '0;
            syn_b <= '0;
            syn_c <= '0;
        end
        else
        begin
            syn_a <= {trap_in, rst75_in, rst65_in, rst55_in, general_irq, hold_req, ready};
            syn_b <= syn_a;
            syn_c <= syn_b;
        end
    end

    wire ready_s = syn_b[SYN_READY];
    wire hold_s  = syn_b[SYN_HOLD];
    wire general_irq_s  = syn_b[SYN_GENERAL_IRQ];
    wire r55_s   = syn_b[SYN_R55];
    wire r65_s   = syn_b[SYN_R65];
    wire trap_s  = syn_b[SYN_TRAP];
    wire r75_rise  = syn_b[SYN_R75] & ~syn_c[SYN_R75];
    wire trap_rise = syn_b[SYN_TRAP] & ~syn_c[SYN_TRAP];

    // Bus sequencer
    bcirq_state_t state;
    bcirq_state_t next_state;
    bcirq_xfer_t  cur;
    logic         ack_cyc;
    logic         bus_own;
    logic         strobe_lo;
    logic         wdata_drv;
    logic         irq_ack_strobe_pend;

    wire in_strobe = (state == ST_T2) || (state == ST_TW);

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (hold_s)
                    next_state = ST_GRANT;
                else if (xfer_req)
                    next_state = ST_T1;
            ST_T1:
                next_state = ST_T2;
            ST_T2, ST_TW:
                next_state = ready_s ? ST_T3 : ST_TW;
            ST_T3:
                next_state = hold_s ? ST_GRANT : ST_IDLE;
            ST_GRANT:
                next_state = ST_HELD;
            ST_HELD:
                next_state = hold_s ? ST_HELD : ST_RESUME;
            ST_RESUME:
                next_state = ST_IDLE;
        endcase
    end

    wire next_own    = (next_state != ST_HELD) && (next_state != ST_RESUME);
    wire next_strobe = (next_state == ST_T2) || (next_state == ST_TW);
    wire next_wdrv   = next_own && cur.write &&
                       ((next_state == ST_T2) || (next_state == ST_TW) || (next_state == ST_T3));
    wire next_grant  = (next_state == ST_GRANT) || (next_state == ST_HELD);
    wire start_xfer  = (state == ST_IDLE) && (next_state == ST_T1);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state         <= ST_IDLE;
            cur           <= '0;
            ack_cyc       <= 1'b0;
            bus_own       <= 1'b0;
            strobe_lo     <= 1'b0;
            wdata_drv     <= 1'b0;
            bus_grant_out <= RST_GRANT;
            xfer_rdata    <= 8'h00;
        end
        else
        begin
            state         <= next_state;
            bus_own       <= next_own;
            strobe_lo     <= next_strobe;
            wdata_drv     <= next_wdrv;
            bus_grant_out <= next_grant;
            if (start_xfer)
            begin
                cur     <= xfer_cmd;
                ack_cyc <= irq_ack_strobe_pend;
            end
            // Data answers our own strobe on this clock
            if (in_strobe && ready_s && !cur.write)
                xfer_rdata <= data_in;
        end
    end

    // Pin drive; internal work stays free while held
    assign addr_out  = cur.addr;
    assign data_out  = cur.wdata;
    assign io_mem    = cur.io;
    assign addr_oe   = bus_own;
    assign io_mem_oe = bus_own;
    assign data_oe   = wdata_drv;
    assign rd_oe     = bus_own && !halted;
    assign wr_oe     = bus_own && !halted;
    assign rd_n      = ~(strobe_lo && !cur.write && !ack_cyc);
    assign wr_n      = ~(strobe_lo && cur.write);
    assign irq_ack_strobe_n = ~(strobe_lo && ack_cyc);
    assign xfer_done = (state == ST_T3);
    assign pc_clear  = !arst_n;

    // Interrupt intake
    logic       ie;
    logic [2:0] mask;
    logic       pend75;
    logic       pend_trap;
    logic [2:0] take_src;

    wire sample_pt = instr_sample || halted || (state == ST_HELD);
    wire busy      = irq_ack_strobe_pend || irq_take;
    wire trap_go   = pend_trap && trap_s;
    wire r75_go    = pend75 && !mask[MASK_R75_BIT] && ie;
    wire r65_go    = r65_s && !mask[MASK_R65_BIT] && ie;
    wire r55_go    = r55_s && !mask[MASK_R55_BIT] && ie;
    wire general_irq_go   = general_irq_s && ie;
    wire [2:0] sel = trap_go ? SRC_TRAP :
                     r75_go  ? SRC_R75  :
                     r65_go  ? SRC_R65  :
                     r55_go  ? SRC_R55  :
                     general_irq_go ? SRC_GENERAL_IRQ : SRC_NONE;
    wire take_now  = sample_pt && !busy && (sel != SRC_NONE);

    // Register bus decode
    logic av_ack;
    wire  av_req   = avs_read || avs_write;
    wire  av_wr    = avs_write && av_ack && avs_byteenable[0];
    wire  wr_ctrl  = av_wr && (avs_address == ADDR_CTRL);
    wire  wr_mask  = av_wr && (avs_address == ADDR_MASK);
    wire  clr75    = wr_mask && avs_writedata[MASK_CLR75_BIT];
    wire  ack_done = ack_cyc && (state == ST_T3);

    wire next_ie = take_now ? 1'b0 :
                   wr_ctrl  ? avs_writedata[CTRL_IE_BIT] : ie;
    wire next_pend75 = r75_rise ||
                       (pend75 && !(take_now && sel == SRC_R75) && !clr75);
    wire next_pend_trap = trap_rise ||
                          (pend_trap && !(take_now && sel == SRC_TRAP));
    wire next_irq_ack_strobe = (take_now && sel == SRC_GENERAL_IRQ) || (irq_ack_strobe_pend && !ack_done);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ie        <= RST_IE;
            mask      <= RST_MASK;
            pend75    <= 1'b0;
            pend_trap <= 1'b0;
            irq_ack_strobe_pend <= 1'b0;
            irq_take  <= 1'b0;
            irq_info  <= '0;
            take_src  <= SRC_NONE;
        end
        else
        begin
            ie        <= next_ie;
            pend75    <= next_pend75;
            pend_trap <= next_pend_trap;
            irq_ack_strobe_pend <= next_irq_ack_strobe;
            irq_take  <= take_now;
            if (wr_mask)
                mask <= avs_writedata[2:0];
            if (take_now)
            begin
                irq_info.vector   <= vec_of(sel);
                irq_info.external <= (sel == SRC_GENERAL_IRQ);
                take_src          <= sel;
            end
        end
    end

    assign pc_inhibit = irq_ack_strobe_pend;

    // Avalon slave: one wait cycle, unmapped reads zero
    logic [31:0] status_word;
    wire  [31:0] rd_mux = (avs_address == ADDR_CTRL)   ? {31'h0, ie} :
                          (avs_address == ADDR_MASK)   ? {29'h0, mask} :
                          (avs_address == ADDR_STATUS) ? status_word : 32'h0000_0000;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[STAT_IE_BIT]    = ie;
        status_word[STAT_P55_BIT]   = r55_s;
        status_word[STAT_P65_BIT]   = r65_s;
        status_word[STAT_P75_BIT]   = pend75;
        status_word[STAT_TRAP_BIT]  = pend_trap;
        status_word[STAT_GENERAL_IRQ_BIT]  = general_irq_s;
        status_word[STAT_ACK_BIT]   = irq_ack_strobe_pend;
        status_word[STAT_GRANT_BIT] = bus_grant_out;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            av_ack       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            av_ack <= av_req && !av_ack;
            if (avs_read && !av_ack)
                avs_readdata <= rd_mux;
        end
    end

    assign avs_waitrequest = av_req && !av_ack;

    // Checks
    property p_held_float;
        @(posedge clk_sys) disable iff (!arst_n)
        (state == ST_HELD) |-> (!rd_oe && !wr_oe && !addr_oe && !data_oe && !io_mem_oe);
    endproperty
    a_held_float: assert property (p_held_float) else $error("bus driven while held");

    property p_halt_float;
        @(posedge clk_sys) disable iff (!arst_n)
        halted |-> (!rd_oe && !wr_oe);
    endproperty
    a_halt_float: assert property (p_halt_float) else $error("strobes driven in halt");

    property p_grant_release;
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(bus_grant_out) |-> addr_oe ##1 (!addr_oe && bus_grant_out);
    endproperty
    a_grant_release: assert property (p_grant_release) else $error("release not one cycle after grant");

    property p_wait_state;
        @(posedge clk_sys) disable iff (!arst_n)
        (in_strobe && !ready_s) |=> (state == ST_TW) && strobe_lo;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("transfer ended without ready");

    property p_no_reclaim;
        @(posedge clk_sys) disable iff (!arst_n)
        (state == ST_HELD && hold_s) |=> (state == ST_HELD) && bus_grant_out;
    endproperty
    a_no_reclaim: assert property (p_no_reclaim) else $error("bus reclaimed under request");

    property p_resume;
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(bus_grant_out) |-> !addr_oe ##1 addr_oe;
    endproperty
    a_resume: assert property (p_resume) else $error("bus not resumed a cycle after grant fall");

    property p_ie_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        irq_take |-> !ie;
    endproperty
    a_ie_clear: assert property (p_ie_clear) else $error("enable survived acceptance");

    property p_trap_first;
        @(posedge clk_sys) disable iff (!arst_n)
        (take_now && trap_go) |=> (irq_info.vector == VEC_TRAP) && !irq_info.external;
    endproperty
    a_trap_first: assert property (p_trap_first) else $error("trap not given top rank");

    property p_masked;
        @(posedge clk_sys) disable iff (!arst_n)
        (irq_take && take_src == SRC_R75) |-> !$past(mask[MASK_R75_BIT]);
    endproperty
    a_masked: assert property (p_masked) else $error("masked restart accepted");

    property p_sample_point;
        @(posedge clk_sys) disable iff (!arst_n)
        irq_take |-> $past(sample_pt);
    endproperty
    a_sample_point: assert property (p_sample_point) else $error("accepted off sample point");

    property p_ack_strobe;
        @(posedge clk_sys) disable iff (!arst_n)
        (strobe_lo && ack_cyc) |-> (rd_n && !irq_ack_strobe_n && pc_inhibit);
    endproperty
    a_ack_strobe: assert property (p_ack_strobe) else $error("read strobe during acknowledge");

endmodule : bcirq_top
`default_nettype wire

// ===== bcirq_top_dummy_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== bcirq_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcirq_mem_model
#(
    parameter logic [7:0] ACK_OPC = 8'hff
)
(
    // Clock
    input  wire  logic        clk_sys,
    // Bus pins
    input  wire  logic [15:0] addr_out,
    input  wire  logic [7:0]  data_out,
    input  wire  logic        data_oe,
    input  wire  logic        rd_n,
    input  wire  logic        wr_n,
    input  wire  logic        irq_ack_strobe_n,
    // Stall control
    input  wire  logic [3:0]  wait_n,
    output logic              ready,
    output logic [7:0]        data_in
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h5a;
    logic [3:0] cnt = 4'h0;
    logic       wr_low = 1'b0;
    wire        strobe = !rd_n || !wr_n || !irq_ack_strobe_n;
    // Ready held low for wait_n strobe cycles
    assign ready = (cnt >= wait_n);
    // Opcode on acknowledge, memory on read, else changing junk
    assign data_in = !irq_ack_strobe_n ? ACK_OPC : (!rd_n ? mem[addr_out[7:0]] : ~last);
    always_ff @(posedge clk_sys)
    begin
        last   <= data_in;
        cnt    <= strobe ? cnt + 4'h1 : 4'h0;
        wr_low <= !wr_n;
        // Store at trailing edge of write strobe
        if (wr_low && wr_n && data_oe)
            mem[addr_out[7:0]] <= data_out;
    end
endmodule : bcirq_mem_model
`default_nettype wire

// ===== test_bcirq_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_bcirq_top
    import bcirq_pkg::*;
;
    logic        clk_sys, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable, wait_n;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        xfer_req, xfer_done, instr_sample, halted, irq_take, pc_inhibit, pc_clear;
    bcirq_xfer_t xfer_cmd;
    bcirq_irq_t  irq_info;
    logic [7:0]  xfer_rdata, data_in, data_out, vec;
    logic [15:0] addr_out;
    logic        addr_oe, data_oe, rd_n, rd_oe, wr_n, wr_oe, io_mem, io_mem_oe;
    logic        irq_ack_strobe_n, ready, hold_req, bus_grant_out, took, ext;
    logic        saw_rd, saw_wr, saw_ack, saw_grant;
    logic [4:0]  pins;
    int          failures = 0, tests_run = 0, cycles = 0, c1, c2, n;
    logic [4:0]  pv [4] = '{5'b11111, 5'b01110, 5'b00110, 5'b00011};
    logic [7:0]  ev [4] = '{VEC_TRAP, VEC_R75, VEC_R65, VEC_R55};

    bcirq_top dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xfer_req(xfer_req),
        .xfer_cmd(xfer_cmd), .xfer_done(xfer_done), .xfer_rdata(xfer_rdata),
        .instr_sample(instr_sample), .halted(halted), .irq_take(irq_take), .irq_info(irq_info),
        .pc_inhibit(pc_inhibit), .pc_clear(pc_clear), .addr_out(addr_out), .addr_oe(addr_oe),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .rd_oe(rd_oe),
        .wr_n(wr_n), .wr_oe(wr_oe), .io_mem(io_mem), .io_mem_oe(io_mem_oe),
        .irq_ack_strobe_n(irq_ack_strobe_n), .ready(ready), .hold_req(hold_req),
        .bus_grant_out(bus_grant_out), .general_irq(pins[0]), .rst55_in(pins[1]),
        .rst65_in(pins[2]), .rst75_in(pins[3]), .trap_in(pins[4]));

    bcirq_mem_model #(.ACK_OPC(8'hff)) mem_i (
        .clk_sys(clk_sys), .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
        .rd_n(rd_n), .wr_n(wr_n), .irq_ack_strobe_n(irq_ack_strobe_n), .wait_n(wait_n),
        .ready(ready), .data_in(data_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task complete_run;
        $display("Checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            complete_run;
        end
    end

    // Avalon access, held until waitrequest sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : av

    // Core transfer, held until done
    task automatic bus_op(input logic wr, input logic [15:0] a, input logic [7:0] d,
                          output int cyc);
        @(posedge clk_sys);
        xfer_cmd <= '{addr: a, wdata: d, write: wr, io: 1'b0};
        xfer_req <= 1'b1;
        {saw_rd, saw_wr, saw_ack, saw_grant} = 4'h0;
        cyc = 0;
        do
        begin
            @(posedge clk_sys);
            cyc++;
            saw_rd    |= (rd_n === 1'b0);
            saw_wr    |= (wr_n === 1'b0);
            saw_ack   |= (irq_ack_strobe_n === 1'b0);
            saw_grant |= (bus_grant_out === 1'b1);
        end while (xfer_done !== 1'b1 && cyc < 60);
        vec = xfer_rdata;
        xfer_req <= 1'b0;
    endtask : bus_op

    // Raise pins, pulse the sample point, catch the acceptance
    task automatic fire(input logic [4:0] p);
        @(posedge clk_sys);
        pins <= p;
        took = 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            @(posedge clk_sys);
            instr_sample <= (k == 3);
            if (irq_take === 1'b1 && !took)
            begin
                took = 1'b1;
                q    = 32'(irq_info.vector);
                ext  = irq_info.external;
            end
        end
        pins <= 5'h00;
        repeat (4) @(posedge clk_sys);
    endtask : fire

    task t_regs;
        av(1'b0, ADDR_MASK, 32'h0);
        check(32'(q[2:0]), 32'(RST_MASK));
        av(1'b0, ADDR_STATUS, 32'h0);
        check(32'({q[STAT_IE_BIT], q[STAT_GRANT_BIT]}), 32'h0000_0000);
        av(1'b0, 4'hc, 32'h0);
        check(q, 32'h0000_0000);
        avs_byteenable <= 4'h0;
        av(1'b1, ADDR_CTRL, 32'h0000_0001);
        avs_byteenable <= 4'h1;
        av(1'b0, ADDR_CTRL, 32'h0);
        check(q, 32'h0000_0000);
        halted <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(32'({rd_oe, wr_oe}), 32'h0000_0000);
        halted <= 1'b0;
    endtask : t_regs

    task t_xfer;
        bus_op(1'b1, 16'h0012, 8'h3c, c1);
        check(32'({saw_wr, saw_rd}), 32'h0000_0002);
        bus_op(1'b0, 16'h0012, 8'h00, c1);
        check(32'({vec, saw_rd, saw_wr}), 32'h0000_00f2);
        wait_n <= 4'h3;
        bus_op(1'b0, 16'h0012, 8'h00, c2);
        check(32'({vec, c2 == c1 + 5}), 32'h0000_0079);
    endtask : t_xfer

    task t_hold;
        wait_n <= 4'h3;
        fork
            bus_op(1'b0, 16'h0012, 8'h00, c1);
            begin
                repeat (3) @(posedge clk_sys);
                hold_req <= 1'b1;
            end
        join
        wait_n <= 4'h0;
        check(32'(saw_grant), 32'h0000_0000);
        n = 0;
        while (bus_grant_out !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(addr_oe), 32'h0000_0001);
        @(posedge clk_sys);
        check(32'({addr_oe, data_oe, rd_oe, wr_oe, io_mem_oe}), 32'h0000_0000);
        fire(5'b10000);
        check(32'({took, q[7:0]}), 32'h0000_0124);
        check(32'({bus_grant_out, addr_oe}), 32'h0000_0002);
        hold_req <= 1'b0;
        n = 0;
        while (bus_grant_out !== 1'b0 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(addr_oe), 32'h0000_0000);
        @(posedge clk_sys);
        check(32'(addr_oe), 32'h0000_0001);
    endtask : t_hold

    task t_irq;
        av(1'b1, ADDR_MASK, 32'h0000_0010);
        for (int i = 0; i < 4; i++)
        begin
            av(1'b1, ADDR_CTRL, 32'h0000_0001);
            fire(pv[i]);
            check(32'({took, q[7:0]}), 32'({1'b1, ev[i]}));
        end
        av(1'b1, ADDR_MASK, 32'h0000_0012);
        av(1'b1, ADDR_CTRL, 32'h0000_0001);
        fire(5'b00100);
        check(32'(took), 32'h0000_0000);
        fire(5'b00001);
        check(32'({took, ext, pc_inhibit}), 32'h0000_0007);
        av(1'b0, ADDR_STATUS, 32'h0);
        check(32'(q[STAT_IE_BIT]), 32'h0000_0000);
        bus_op(1'b0, 16'h0040, 8'h00, c1);
        check(32'({vec, saw_ack, saw_rd}), 32'h0000_03fe);
    endtask : t_irq

    initial
    begin
        arst_n = 1'b0;
        {avs_read, avs_write, xfer_req, instr_sample, halted, hold_req} = 6'h00;
        avs_address    = 4'h0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h1;
        xfer_cmd       = '0;
        pins           = 5'h00;
        wait_n         = 4'h0;
        repeat (3) @(posedge clk_sys);
        check(32'({addr_oe, data_oe, rd_oe, wr_oe, io_mem_oe, bus_grant_out, pc_clear}),
              32'h0000_0001);
        arst_n <= 1'b1;
        t_regs;
        t_xfer;
        t_hold;
        t_irq;
        complete_run;
    end
endmodule : test_bcirq_top
`default_nettype wire
